// File: core/bcnt_top.sv
`timescale 1ns/1ps
`default_nettype none

module bcnt_top (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire bcnt_pkg::bcnt_wb_req_s wb_req_i,
    output bcnt_pkg::bcnt_wb_rsp_s wb_rsp_o,
    // External count pin
    input wire logic ext_count_pin_i,
    // Interrupt
    input wire logic irq_ack_i,
    output logic irq_o,
    // Shared prescaler reset
    input wire logic shared_prescaler_reset_i,
    output logic shared_prescaler_reset_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers and nets

    logic [2:0] clock_select_field_q;
    logic [7:0] timer_count_value_q;
    logic [7:0] timer_irq_mask_q;
    logic overflow_flag_q;
    logic gie_q;
    logic psc_rst_q;
    logic [bcnt_pkg::PSC_W-1:0] psc_q;
    logic irq_q;
    logic ack_q;
    logic [31:0] rdat_q;

    logic req;
    logic acc;
    logic wr_en;
    logic rd_done;
    logic [7:0] wdat;
    logic [7:0] rdat_d;
    logic timer_tick;
    logic ext_rise;
    logic ext_fall;
    logic cnt_wr;
    logic ovf_set;
    logic ovf_clr;

    ////////////////////////////////////////////////////////////////////////////
    // Bus decode

    assign req = wb_req_i.cyc & wb_req_i.stb;
    // The access completes at the edge where ack is high
    assign acc = req & ack_q;
    assign wr_en = acc & wb_req_i.we & wb_req_i.sel[0];
    assign rd_done = acc & ~wb_req_i.we;
    assign wdat = wb_req_i.dat[7:0];

    always_comb
    begin
        rdat_d = 8'h00;
        case (wb_req_i.adr)
            bcnt_pkg::OFS_CONTROL:
            begin
                rdat_d = {5'h00, clock_select_field_q};
            end
            bcnt_pkg::OFS_COUNT:
            begin
                rdat_d = timer_count_value_q;
            end
            bcnt_pkg::OFS_MASK:
            begin
                rdat_d = timer_irq_mask_q;
            end
            bcnt_pkg::OFS_FLAGS:
            begin
                rdat_d[bcnt_pkg::OVF_BIT] = overflow_flag_q;
            end
            bcnt_pkg::OFS_GIE:
            begin
                rdat_d[bcnt_pkg::GIE_BIT] = gie_q;
            end
            default:
            begin
                // Prescaler reset and unmapped addresses read zero
                rdat_d = 8'h00;
            end
        endcase
    end

    // Every address is acknowledged so a stray access never hangs the bus
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            ack_q <= req & ~ack_q;
            if (req & ~ack_q)
            begin
                rdat_q <= {24'h00_0000, rdat_d};
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            clock_select_field_q <= bcnt_pkg::CONTROL_RST[2:0];
        end
        // The three select field bits are the only stored bits
        else if (ce_i && wr_en && wb_req_i.adr == bcnt_pkg::OFS_CONTROL)
        begin
            clock_select_field_q <= wdat[bcnt_pkg::CS_LSB +: bcnt_pkg::CS_W];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timer_irq_mask_q <= bcnt_pkg::MASK_RST;
        end
        else if (ce_i && wr_en && wb_req_i.adr == bcnt_pkg::OFS_MASK)
        begin
            timer_irq_mask_q <= wdat;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            gie_q <= bcnt_pkg::GIE_RST;
        end
        else if (ce_i && wr_en && wb_req_i.adr == bcnt_pkg::OFS_GIE)
        begin
            gie_q <= wdat[bcnt_pkg::GIE_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Prescaler

    // Reset request is a one-cycle pulse, also sent to the other timer
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            psc_rst_q <= 1'b0;
        end
        else if (ce_i)
        begin
            psc_rst_q <= wr_en && wb_req_i.adr == bcnt_pkg::OFS_PSC
                && wdat[bcnt_pkg::PSC_RST_BIT];
        end
    end

    // Runs regardless of the select field
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            psc_q <= '0;
        end
        else if (ce_i)
        begin
            if (psc_rst_q | shared_prescaler_reset_i)
            begin
                psc_q <= '0;
            end
            else
            begin
                psc_q <= psc_q + 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External pin

    // Pin level is read whatever drives it
    bcnt_pin_edge u_pin_edge (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .ce_i (ce_i),
        .pin_i (ext_count_pin_i),
        .rise_o (ext_rise),
        .fall_o (ext_fall)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Tick select

    always_comb
    begin
        timer_tick = 1'b0;
        case (bcnt_pkg::bcnt_clksel_e'(clock_select_field_q))
            bcnt_pkg::CS_STOP:
            begin
                timer_tick = 1'b0;
            end
            bcnt_pkg::CS_DIV1:
            begin
                timer_tick = 1'b1;
            end
            bcnt_pkg::CS_DIV8:
            begin
                timer_tick = (psc_q & bcnt_pkg::TAP_DIV8) == bcnt_pkg::TAP_DIV8;
            end
            bcnt_pkg::CS_DIV64:
            begin
                timer_tick = (psc_q & bcnt_pkg::TAP_DIV64) == bcnt_pkg::TAP_DIV64;
            end
            bcnt_pkg::CS_DIV256:
            begin
                timer_tick = (psc_q & bcnt_pkg::TAP_DIV256) == bcnt_pkg::TAP_DIV256;
            end
            bcnt_pkg::CS_DIV1024:
            begin
                timer_tick = psc_q == bcnt_pkg::TAP_DIV1024;
            end
            bcnt_pkg::CS_EXT_FALL:
            begin
                timer_tick = ext_fall;
            end
            bcnt_pkg::CS_EXT_RISE:
            begin
                timer_tick = ext_rise;
            end
            default:
            begin
                timer_tick = 1'b0;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter

    assign cnt_wr = wr_en && wb_req_i.adr == bcnt_pkg::OFS_COUNT;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            timer_count_value_q <= bcnt_pkg::COUNT_RST;
        end
        else if (ce_i)
        begin
            if (cnt_wr)
            begin
                timer_count_value_q <= wdat;
            end
            else if (timer_tick)
            begin
                timer_count_value_q <= timer_count_value_q + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Overflow flag and interrupt

    assign ovf_set = timer_tick & ~cnt_wr & (timer_count_value_q == bcnt_pkg::CNT_MAX);

    // Service, write-one, or read of a set flag clears it
    assign ovf_clr = irq_ack_i
        | (wr_en && wb_req_i.adr == bcnt_pkg::OFS_FLAGS && wdat[bcnt_pkg::OVF_BIT])
        | (rd_done && wb_req_i.adr == bcnt_pkg::OFS_FLAGS && rdat_q[bcnt_pkg::OVF_BIT]);

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            overflow_flag_q <= 1'b0;
        end
        else if (ce_i)
        begin
            // Counting only sets; a set in the clear cycle wins
            overflow_flag_q <= ovf_set | (overflow_flag_q & ~ovf_clr);
        end
    end

    // Registered, so the request trails the flag by one cycle
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            irq_q <= 1'b0;
        end
        else if (ce_i)
        begin
            irq_q <= overflow_flag_q & timer_irq_mask_q[bcnt_pkg::OVF_IE_BIT] & gie_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs

    assign wb_rsp_o.ack = ack_q;
    assign wb_rsp_o.dat = rdat_q;
    assign irq_o = irq_q;
    assign shared_prescaler_reset_o = psc_rst_q;

endmodule : bcnt_top

`default_nettype wire

// File: common/bcnt_pkg.sv
package bcnt_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses)
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_COUNT = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_FLAGS = 8'h0c;
    localparam logic [7:0] OFS_PSC = 8'h10;
    localparam logic [7:0] OFS_GIE = 8'h14;

    ////////////////////////////////////////////////////////////////////////////
    // Field positions and widths
    localparam int CS_LSB = 0;
    localparam int CS_W = 3;
    localparam int OVF_BIT = 0;
    localparam int OVF_IE_BIT = 0;
    localparam int PSC_RST_BIT = 0;
    localparam int GIE_BIT = 0;
    localparam int REG_W = 8;

    ////////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic GIE_RST = 1'b0;

    ////////////////////////////////////////////////////////////////////////////
    // Counter and prescaler constants
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam int PSC_W = 10;
    localparam logic [9:0] TAP_DIV8 = 10'h007;
    localparam logic [9:0] TAP_DIV64 = 10'h03f;
    localparam logic [9:0] TAP_DIV256 = 10'h0ff;
    localparam logic [9:0] TAP_DIV1024 = 10'h3ff;

    typedef enum logic [2:0] {
        CS_STOP = 3'h0,
        CS_DIV1 = 3'h1,
        CS_DIV8 = 3'h2,
        CS_DIV64 = 3'h3,
        CS_DIV256 = 3'h4,
        CS_DIV1024 = 3'h5,
        CS_EXT_FALL = 3'h6,
        CS_EXT_RISE = 3'h7
    } bcnt_clksel_e;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [3:0] sel;
        logic [31:0] dat;
    } bcnt_wb_req_s;

    typedef struct packed {
        logic ack;
        logic [31:0] dat;
    } bcnt_wb_rsp_s;

endpackage : bcnt_pkg

// File: core/bcnt_pin_edge.sv
`timescale 1ns/1ps
`default_nettype none

module bcnt_pin_edge (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Pin and edge pulses
    input wire logic pin_i,
    output logic rise_o,
    output logic fall_o
);

    logic sync_q;
    logic samp_q;
    logic prev_q;

    // First stage feeds only the second
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            sync_q <= 1'b0;
            samp_q <= 1'b0;
            prev_q <= 1'b0;
        end
        else if (ce_i)
        begin
            sync_q <= pin_i;
            samp_q <= sync_q;
            prev_q <= samp_q;
        end
    end

    assign rise_o = samp_q & ~prev_q;
    assign fall_o = ~samp_q & prev_q;

endmodule : bcnt_pin_edge

`default_nettype wire

// File: verif/bcnt_top_properties.sv
`timescale 1ns/1ps
`default_nettype none

module bcnt_top_checker (
    // Clock, reset, enable
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Bus
    input wire bcnt_pkg::bcnt_wb_req_s wb_req_i,
    input wire bcnt_pkg::bcnt_wb_rsp_s wb_rsp_o,
    // Pins
    input wire logic ext_count_pin_i,
    input wire logic irq_ack_i,
    input wire logic irq_o,
    input wire logic shared_prescaler_reset_i,
    input wire logic shared_prescaler_reset_o
);
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    ack_resp_a: assert property (
        wb_req_i.cyc && wb_req_i.stb && !wb_rsp_o.ack && ce_i |=> wb_rsp_o.ack)
        else $error("bus request not answered");
    ack_pulse_a: assert property (
        wb_rsp_o.ack && ce_i |=> !wb_rsp_o.ack)
        else $error("ack longer than one cycle");
    ctrl_read_a: assert property (
        wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr == bcnt_pkg::OFS_CONTROL
        |-> wb_rsp_o.dat[31:3] == 29'h0) else $error("control upper bits not zero");
    psc_read_a: assert property (
        wb_rsp_o.ack && !wb_req_i.we && wb_req_i.adr == bcnt_pkg::OFS_PSC
        |-> wb_rsp_o.dat == 32'h0) else $error("prescaler reset reads nonzero");
    psc_pulse_a: assert property (
        wb_rsp_o.ack && wb_req_i.we && wb_req_i.adr == bcnt_pkg::OFS_PSC
        && wb_req_i.sel[0] && wb_req_i.dat[0] |-> ##[1:2] shared_prescaler_reset_o)
        else $error("no prescaler reset pulse");
    psc_single_a: assert property (
        shared_prescaler_reset_o && ce_i |=> !shared_prescaler_reset_o)
        else $error("prescaler reset pulse too long");
    irq_clear_a: assert property (
        irq_ack_i && ce_i ##1 ce_i |=> !irq_o) else $error("interrupt not cleared by service");
    ce_freeze_a: assert property (
        !ce_i |=> $stable(wb_rsp_o) && $stable(irq_o) && $stable(shared_prescaler_reset_o))
        else $error("outputs moved while enable low");
    irq_rise_a: assert property (
        $rose(irq_o) |-> !irq_ack_i) else $error("interrupt rose during service");
endmodule : bcnt_top_checker

bind bcnt_top bcnt_top_checker bcnt_top_checker_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_req_i(wb_req_i), .wb_rsp_o(wb_rsp_o),
    .ext_count_pin_i(ext_count_pin_i), .irq_ack_i(irq_ack_i), .irq_o(irq_o),
    .shared_prescaler_reset_i(shared_prescaler_reset_i),
    .shared_prescaler_reset_o(shared_prescaler_reset_o)
);

`default_nettype wire

// File: verif/bcnt_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module bcnt_pin_model (
    // Clock
    input wire logic clk_i,
    // Count pin
    output logic pin_o
);
    initial pin_o = 1'b0;

    // slow edges
    // Each level held two cycles so every edge is sampled
    task automatic pulses(input int n);
        repeat (n)
        begin
            repeat (2) @(posedge clk_i);
            pin_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            pin_o <= 1'b0;
        end
        repeat (6) @(posedge clk_i);
    endtask : pulses
endmodule : bcnt_pin_model

`default_nettype wire

// File: verif/tb.sv
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic irq_ack = 1'b0;
    logic ce = 1'b1;
    logic psc_in = 1'b0;
    logic psc_out;
    logic irq;
    logic pin;
    bcnt_pkg::bcnt_wb_req_s req = '0;
    bcnt_pkg::bcnt_wb_rsp_s rsp;
    int fails = 0;
    int n_tests = 0;
    int cyc_n = 0;
    logic [7:0] rv;
    int cv;

    always #4 clk_i = ~clk_i;
    always @(posedge clk_i) cyc_n <= cyc_n + 1;

    bcnt_top bcnt_top_inst (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_req_i(req), .wb_rsp_o(rsp),
        .ext_count_pin_i(pin), .irq_ack_i(irq_ack), .irq_o(irq),
        .shared_prescaler_reset_i(psc_in), .shared_prescaler_reset_o(psc_out)
    );
    bcnt_pin_model bcnt_pin_model_inst (.clk_i(clk_i), .pin_o(pin));

    ////////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (fails == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : test_done

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        n_tests++;
        if (g !== e)
        begin
            fails++;
            $display("mismatch at %0t: got %h exp %h", $time, g, e);
        end
    endtask : chk

    // Read: cv is the capture edge; write: cv is the ack edge
    task automatic bus(input logic we, input logic [7:0] a, input logic [7:0] d);
        int t;
        t = 0;
        req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: a, sel: 4'h1, dat: {24'h0, d}};
        @(posedge clk_i);
        cv = cyc_n;
        do
        begin
            @(posedge clk_i);
            t++;
        end
        while (rsp.ack !== 1'b1 && t < 20);
        if (t >= 20)
            fails++;
        rv = rsp.dat[7:0];
        if (we)
            cv = cyc_n;
        req <= '0;
        @(posedge clk_i);
    endtask : bus

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        bus(1'b0, a, 8'h00);
        chk(rv, e);
    endtask : rd_chk

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd_chk(bcnt_pkg::OFS_CONTROL, 8'h00);
        rd_chk(bcnt_pkg::OFS_COUNT, 8'h00);
        rd_chk(bcnt_pkg::OFS_MASK, 8'h00);
        rd_chk(bcnt_pkg::OFS_FLAGS, 8'h00);
        bus(1'b1, bcnt_pkg::OFS_CONTROL, 8'hf8);
        rd_chk(bcnt_pkg::OFS_CONTROL, 8'h00);
        bus(1'b1, bcnt_pkg::OFS_MASK, 8'ha5);
        rd_chk(bcnt_pkg::OFS_MASK, 8'ha5);
        bus(1'b1, bcnt_pkg::OFS_PSC, 8'h01);
        rd_chk(bcnt_pkg::OFS_PSC, 8'h00);
        rd_chk(8'h20, 8'h00);
    endtask : t_regs

    task automatic t_stop;
        bus(1'b1, bcnt_pkg::OFS_COUNT, 8'h5a);
        repeat (50) @(posedge clk_i);
        rd_chk(bcnt_pkg::OFS_COUNT, 8'h5a);
    endtask : t_stop

    task automatic t_pin;
        bus(1'b1, bcnt_pkg::OFS_COUNT, 8'h00);
        bus(1'b1, bcnt_pkg::OFS_CONTROL, 8'h06);
        bcnt_pin_model_inst.pulses(5);
        rd_chk(bcnt_pkg::OFS_COUNT, 8'h05);
        bus(1'b1, bcnt_pkg::OFS_CONTROL, 8'h07);
        bcnt_pin_model_inst.pulses(3);
        rd_chk(bcnt_pkg::OFS_COUNT, 8'h08);
    endtask : t_pin

    task automatic wrap(input logic [7:0] m);
        bus(1'b1, bcnt_pkg::OFS_MASK, m);
        bus(1'b1, bcnt_pkg::OFS_COUNT, 8'hff);
        bcnt_pin_model_inst.pulses(1);
    endtask : wrap

    task automatic t_ovf;
        bus(1'b1, bcnt_pkg::OFS_GIE, 8'h01);
        wrap(8'h01);
        rd_chk(bcnt_pkg::OFS_COUNT, 8'h00);
        chk({7'h0, irq}, 8'h01);
        irq_ack <= 1'b1;
        @(posedge clk_i);
        irq_ack <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk({7'h0, irq}, 8'h00);
        wrap(8'h00);
        chk({7'h0, irq}, 8'h00);
        bus(1'b1, bcnt_pkg::OFS_FLAGS, 8'h00);
        rd_chk(bcnt_pkg::OFS_FLAGS, 8'h01);
        rd_chk(bcnt_pkg::OFS_FLAGS, 8'h00);
        wrap(8'h00);
        bus(1'b1, bcnt_pkg::OFS_FLAGS, 8'h01);
        rd_chk(bcnt_pkg::OFS_FLAGS, 8'h00);
    endtask : t_ovf

    task automatic t_psc;
        int dv[5] = '{1, 8, 64, 256, 1024};
        int c0;
        int lo;
        logic [7:0] a;
        logic [7:0] df;
        for (int i = 0; i < 5; i++)
        begin
            bus(1'b1, bcnt_pkg::OFS_CONTROL, 8'(i + 1));
            bus(1'b0, bcnt_pkg::OFS_COUNT, 8'h00);
            a = rv;
            c0 = cv;
            repeat (1800) @(posedge clk_i);
            bus(1'b0, bcnt_pkg::OFS_COUNT, 8'h00);
            df = rv - a;
            lo = (cv - c0) / dv[i];
            chk(df, (df == 8'(lo + 1)) ? df : 8'(lo));
        end
    endtask : t_psc

    task automatic t_run_write;
        int cw;
        bus(1'b1, bcnt_pkg::OFS_CONTROL, 8'h01);
        bus(1'b1, bcnt_pkg::OFS_COUNT, 8'h40);
        cw = cv;
        bus(1'b0, bcnt_pkg::OFS_COUNT, 8'h00);
        chk(rv, 8'(8'h3f + cv - cw));
    endtask : t_run_write

    // Twenty edges with the enable low must not count
    task automatic t_ce;
        int cw;
        bus(1'b1, bcnt_pkg::OFS_CONTROL, 8'h01);
        bus(1'b1, bcnt_pkg::OFS_COUNT, 8'h10);
        cw = cv;
        ce <= 1'b0;
        repeat (20) @(posedge clk_i);
        ce <= 1'b1;
        bus(1'b0, bcnt_pkg::OFS_COUNT, 8'h00);
        chk(rv, 8'(8'h10 + cv - cw - 21));
    endtask : t_ce

    // Outgoing reset pulse, then an incoming one fixes the divide-by-8 phase
    task automatic t_shared;
        int x;
        bus(1'b1, bcnt_pkg::OFS_PSC, 8'h01);
        chk({7'h0, psc_out}, 8'h01);
        @(posedge clk_i);
        chk({7'h0, psc_out}, 8'h00);
        bus(1'b1, bcnt_pkg::OFS_CONTROL, 8'h02);
        x = cyc_n;
        psc_in <= 1'b1;
        @(posedge clk_i);
        psc_in <= 1'b0;
        bus(1'b1, bcnt_pkg::OFS_COUNT, 8'h00);
        repeat (4) @(posedge clk_i);
        bus(1'b0, bcnt_pkg::OFS_COUNT, 8'h00);
        chk(rv, 8'((cv - x - 2) / 8));
        bus(1'b0, bcnt_pkg::OFS_COUNT, 8'h00);
        chk(rv, 8'((cv - x - 2) / 8));
    endtask : t_shared

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        t_regs();
        t_stop();
        t_pin();
        t_ovf();
        t_psc();
        t_run_write();
        t_ce();
        t_shared();
        test_done();
    end

    initial
    begin
        repeat (30000) @(posedge clk_i);
        fails++;
        test_done();
    end
endmodule : tb

`default_nettype wire
